// >>> hdl/cci_pkg.sv
package cci_pkg;
  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int NUM_CMP = 2;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_FLAG = 8'h04;
  localparam logic [7:0] ADR_EN = 8'h08;
  localparam logic [7:0] ADR_EVT = 8'h0C;
  localparam logic [7:0] ADR_MSK = 8'h10;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SEL_BIT = 3;
  localparam int CFG_INV1_BIT = 4;
  localparam int CFG_INV2_BIT = 5;
  localparam int CFG_OUT1_BIT = 6;
  localparam int CFG_OUT2_BIT = 7;
  localparam int FLAG_BIT = 0;
  localparam int FLAG_MM_BIT = 1;
  localparam int EN_LOCAL_BIT = 0;
  localparam int EN_PERIPH_BIT = 1;
  localparam int EN_GLOBAL_BIT = 2;
  localparam int EVT_W = 3;
  localparam int EVT_FLAG_BIT = 0;
  localparam int EVT_MM1_BIT = 1;
  localparam int EVT_MM2_BIT = 2;
  // ************************************************************
  // modes and reset values
  // ************************************************************
  localparam logic [2:0] MODE_ONE = 3'h1;
  localparam logic [2:0] MODE_TWO = 3'h2;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [2:0] EN_RST = 3'h0;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } cci_acc_t;
endpackage

// >>> hdl/cci_mismatch.sv
`timescale 1ns/10ps
module cci_mismatch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic out_i,
  input wire logic phase_i,
  input wire logic capture_i,
  output logic mismatch_o
);
  // ************************************************************
  // snapshot and sampling latches
  // ************************************************************
  logic snap_q;
  logic samp_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_q <= out_i;
    end else if (ce_i && phase_i) begin
      samp_q <= out_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_q <= out_i;
    end else if (ce_i && capture_i) begin
      snap_q <= samp_q;
    end
  end

  assign mismatch_o = snap_q ^ samp_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_sample_load;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && phase_i |=> samp_q == $past(out_i);
  endproperty
  a_sample_load: assert property (p_sample_load)
    else $error("sampling latch missed its load");

  property p_snap_hold;
    @(posedge clk_i) disable iff (rst_i)
    !(ce_i && capture_i) |=> $stable(snap_q);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("snapshot changed without capture");
endmodule

// >>> hdl/cci_top.sv
`timescale 1ns/10ps
// Functional notes
// - input switch only in modes one/two
// - both pins analog, select bit picks pin
// - output change sets change flag
// - config access captures snapshot latch
// - sampling latch reloads every first phase
// - mismatch is snapshot xor sample
// - mismatch keeps forcing flag true
// - config write also refreshes snapshot
// - write zero clears, one sets flag
// - request needs all three enables
// - clear ignored while mismatch persists
// - invert bit inverts reported output
module cci_top #(
  parameter int NUM_CMP = cci_pkg::NUM_CMP
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] cmp_raw_i,
  input wire logic phase_i,
  output logic [1:0] cmp_out_o,
  output logic sw_enable_o,
  output logic sw_select_o,
  output logic analog_hold_o,
  output logic change_flag_o,
  output logic cmp_irq_o,
  output logic irq_o
);
  // ************************************************************
  // elaboration check
  // ************************************************************
  if (NUM_CMP != 2) begin : g_bad
    $error("cci_top serves exactly two comparators");
  end

  // ************************************************************
  // state
  // ************************************************************
  logic [2:0] mode_q;
  logic sel_q;
  logic [1:0] inv_q;
  logic [1:0] out_q;
  logic flag_q;
  logic flag_d;
  logic [2:0] en_q;
  logic [2:0] evt_q;
  logic [2:0] evt_d;
  logic [2:0] msk_q;
  logic [1:0] mm;
  logic [1:0] mm_prev_q;
  logic any_mm;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr0;
  cci_pkg::cci_acc_t acc;
  logic cfg_acc;
  logic flag_wr;
  logic evt_rd;
  logic sw_en_q;
  logic sw_sel_q;
  logic hold_q;
  logic cirq_q;
  logic irq_q;
  logic flag_rise;
  logic [1:0] mm_src;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic sw_mode(input logic [2:0] m);
    sw_mode = (m == cci_pkg::MODE_ONE) || (m == cci_pkg::MODE_TWO);
  endfunction

  // ************************************************************
  // bus decode
  // ************************************************************
  assign req = cyc_i && stb_i && !ack_q;
  assign wr0 = req && we_i && sel_i[0];

  always_comb begin
    if (!req) begin
      acc = cci_pkg::ACC_NONE;
    end else if (we_i) begin
      acc = cci_pkg::ACC_WRITE;
    end else begin
      acc = cci_pkg::ACC_READ;
    end
  end

  // any read or write of config outside a first-phase cycle ends mismatch
  assign cfg_acc = (acc != cci_pkg::ACC_NONE) &&
                   hit(adr_i, cci_pkg::ADR_CFG);
  assign flag_wr = wr0 && hit(adr_i, cci_pkg::ADR_FLAG);
  assign evt_rd = (acc == cci_pkg::ACC_READ) && hit(adr_i, cci_pkg::ADR_EVT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= cci_pkg::DAT_ZERO;
    end else if (ce_i && req) begin
      rdat_q <= cci_pkg::DAT_ZERO;
      if (we_i) begin
        rdat_q <= cci_pkg::DAT_ZERO;
      end else if (hit(adr_i, cci_pkg::ADR_CFG)) begin
        rdat_q[cci_pkg::CFG_MODE_LSB +: 3] <= mode_q;
        rdat_q[cci_pkg::CFG_SEL_BIT] <= sel_q;
        rdat_q[cci_pkg::CFG_INV1_BIT] <= inv_q[0];
        rdat_q[cci_pkg::CFG_INV2_BIT] <= inv_q[1];
        rdat_q[cci_pkg::CFG_OUT1_BIT] <= out_q[0];
        rdat_q[cci_pkg::CFG_OUT2_BIT] <= out_q[1];
      end else if (hit(adr_i, cci_pkg::ADR_FLAG)) begin
        rdat_q[cci_pkg::FLAG_BIT] <= flag_q;
        rdat_q[cci_pkg::FLAG_MM_BIT] <= any_mm;
      end else if (hit(adr_i, cci_pkg::ADR_EN)) begin
        rdat_q[2:0] <= en_q;
      end else if (hit(adr_i, cci_pkg::ADR_EVT)) begin
        rdat_q[2:0] <= evt_q;
      end else if (hit(adr_i, cci_pkg::ADR_MSK)) begin
        rdat_q[2:0] <= msk_q;
      end
    end
  end

  // ************************************************************
  // configuration, enable and mask registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= cci_pkg::MODE_RST;
      sel_q <= cci_pkg::CFG_RST[cci_pkg::CFG_SEL_BIT];
      inv_q <= 2'h0;
    end else if (ce_i && wr0 && hit(adr_i, cci_pkg::ADR_CFG)) begin
      mode_q <= dat_i[cci_pkg::CFG_MODE_LSB +: 3];
      sel_q <= dat_i[cci_pkg::CFG_SEL_BIT];
      inv_q <= {dat_i[cci_pkg::CFG_INV2_BIT], dat_i[cci_pkg::CFG_INV1_BIT]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= cci_pkg::EN_RST;
      msk_q <= cci_pkg::EVT_RST;
    end else if (ce_i && wr0) begin
      if (hit(adr_i, cci_pkg::ADR_EN)) begin
        en_q <= dat_i[2:0];
      end else if (hit(adr_i, cci_pkg::ADR_MSK)) begin
        msk_q <= dat_i[2:0];
      end
    end
  end

  // ************************************************************
  // comparator outputs and input switch
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // invert bits are clear in reset, so raw is the reported value
      out_q <= cmp_raw_i;
    end else if (ce_i) begin
      out_q <= cmp_raw_i ^ inv_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_en_q <= 1'b0;
      sw_sel_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (ce_i) begin
      sw_en_q <= sw_mode(mode_q);
      sw_sel_q <= sw_mode(mode_q) && sel_q;
      hold_q <= sw_mode(mode_q);
    end
  end

  // ************************************************************
  // mismatch detectors
  // ************************************************************
  // latches load the live output in reset, so release shows no change
  assign mm_src = rst_i ? cmp_raw_i : out_q;

  for (genvar i = 0; i < 2; i++) begin : g_mm
    cci_mismatch u_mm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .out_i(mm_src[i]),
      .phase_i(phase_i),
      .capture_i(cfg_acc),
      .mismatch_o(mm[i])
    );
  end

  assign any_mm = |mm;

  // ************************************************************
  // change flag
  // ************************************************************
  always_comb begin
    flag_d = flag_q;
    if (flag_wr) begin
      flag_d = dat_i[cci_pkg::FLAG_BIT];
    end
    if (any_mm) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= flag_d;
    end
  end

  assign flag_rise = flag_d && !flag_q;

  // ************************************************************
  // sticky events, mask, interrupts
  // ************************************************************
  always_comb begin
    evt_d = evt_q;
    if (evt_rd) begin
      evt_d = cci_pkg::EVT_RST;
    end
    evt_d[cci_pkg::EVT_FLAG_BIT] = evt_d[cci_pkg::EVT_FLAG_BIT] || flag_rise;
    evt_d[cci_pkg::EVT_MM1_BIT] = evt_d[cci_pkg::EVT_MM1_BIT] ||
                                  (mm[0] && !mm_prev_q[0]);
    evt_d[cci_pkg::EVT_MM2_BIT] = evt_d[cci_pkg::EVT_MM2_BIT] ||
                                  (mm[1] && !mm_prev_q[1]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= cci_pkg::EVT_RST;
      mm_prev_q <= 2'h0;
    end else if (ce_i) begin
      evt_q <= evt_d;
      mm_prev_q <= mm;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cirq_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      cirq_q <= flag_q && (&en_q);
      irq_q <= |(evt_q & msk_q);
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign cmp_out_o = out_q;
  assign sw_enable_o = sw_en_q;
  assign sw_select_o = sw_sel_q;
  assign analog_hold_o = hold_q;
  assign change_flag_o = flag_q;
  assign cmp_irq_o = cirq_q;
  assign irq_o = irq_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_sw_mode;
    @(posedge clk_i) disable iff (rst_i)
    $past(ce_i) |-> sw_enable_o == sw_mode($past(mode_q));
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("switch enable disagrees with mode");

  property p_sw_sel;
    @(posedge clk_i) disable iff (rst_i)
    sw_select_o |-> sw_enable_o && analog_hold_o;
  endproperty
  a_sw_sel: assert property (p_sw_sel)
    else $error("switch select outside switchable mode");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && any_mm |=> change_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("mismatch did not set flag");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && cfg_acc && !phase_i |=> mm == 2'h0;
  endproperty
  a_capture: assert property (p_capture)
    else $error("config access left a mismatch");

  property p_clear_blocked;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && flag_wr && !dat_i[0] && any_mm |=> change_flag_o;
  endproperty
  a_clear_blocked: assert property (p_clear_blocked)
    else $error("flag cleared during mismatch");

  property p_clear_ok;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && flag_wr && !any_mm |=> change_flag_o == $past(dat_i[0]);
  endproperty
  a_clear_ok: assert property (p_clear_ok)
    else $error("flag write not applied");

  property p_cmp_irq;
    @(posedge clk_i) disable iff (rst_i)
    $past(ce_i) |-> cmp_irq_o == ($past(flag_q) && (&$past(en_q)));
  endproperty
  a_cmp_irq: assert property (p_cmp_irq)
    else $error("comparator request wrong");

  property p_invert;
    @(posedge clk_i) disable iff (rst_i)
    $past(ce_i) |-> cmp_out_o == ($past(cmp_raw_i) ^ $past(inv_q));
  endproperty
  a_invert: assert property (p_invert)
    else $error("reported output inversion wrong");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held two cycles");
endmodule

// >>> tb/cci_top_tb_top.sv
`timescale 1ns/10ps
module cci_top_tb_top;
  // ************************************************************
  // clock, reset and stimulus
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [1:0] cmp_raw_i = 2'h0;
  logic phase_i = 1'b0;
  logic [1:0] ph_cnt_q = 2'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [1:0] cmp_out_o;
  logic sw_enable_o;
  logic sw_select_o;
  logic analog_hold_o;
  logic change_flag_o;
  logic cmp_irq_o;
  logic irq_o;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] r;
  logic e;

  always #2 clk_i = ~clk_i;

  // first phase strobe once every four cycles
  always @(posedge clk_i) begin
    ph_cnt_q <= ph_cnt_q + 2'h1;
    phase_i <= (ph_cnt_q == 2'h3);
  end

  cci_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_raw_i(cmp_raw_i), .phase_i(phase_i), .cmp_out_o(cmp_out_o),
    .sw_enable_o(sw_enable_o), .sw_select_o(sw_select_o),
    .analog_hold_o(analog_hold_o), .change_flag_o(change_flag_o),
    .cmp_irq_o(cmp_irq_o), .irq_o(irq_o)
  );

  // ************************************************************
  // report and checks
  // ************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: word %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: bits %b exp %b", $time, got, exp);
    end
  endtask

  // ************************************************************
  // bus cycles and waits
  // ************************************************************
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    bit done;
    done = 1'b0;
    q = 32'h0000_0000;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= d;
    for (int n = 0; n < 20 && !done; n++) begin
      @(posedge clk_i);
      done = (ack_o === 1'b1);
    end
    if (!done) begin
      mismatches++;
      $display("unexpected at %0t: no bus answer", $time);
      conclude();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic drv_raw(input logic [1:0] v);
    @(posedge clk_i);
    cmp_raw_i <= v;
  endtask

  task automatic wait_flag();
    bit done;
    done = 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_i);
      done = (change_flag_o === 1'b1);
    end
    if (!done) begin
      mismatches++;
      $display("unexpected at %0t: change flag stays low", $time);
      conclude();
    end
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] m,
                                      input logic [4:0] hi);
    return {24'h00_0000, hi, m};
  endfunction

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(1);
    chk_b({change_flag_o, irq_o}, 2'h0);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0000_0000, r);
      chk_w(r, 32'h0000_0000);
    end
    // input switch per mode
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, cci_pkg::ADR_CFG, cfg(3'(m), 5'h01), r);
      wt(2);
      e = (m == 1 || m == 2);
      chk_b({sw_enable_o, sw_select_o}, {e, e});
      chk_b({1'b0, analog_hold_o}, {1'b0, e});
      wb(1'b0, cci_pkg::ADR_CFG, 32'h0000_0000, r);
      chk_w(r, cfg(3'(m), 5'h01));
    end
    wb(1'b1, cci_pkg::ADR_CFG, cfg(cci_pkg::MODE_TWO, 5'h00), r);
    // comparator one changes, read of config ends the mismatch
    drv_raw(2'h1);
    wait_flag();
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0003);
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0003);
    wb(1'b0, cci_pkg::ADR_CFG, 32'h0000_0000, r);
    chk_w(r, cfg(cci_pkg::MODE_TWO, 5'h08));
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0001);
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0000);
    // comparator two changes, write of config ends the mismatch
    drv_raw(2'h3);
    wait_flag();
    wb(1'b1, cci_pkg::ADR_CFG, cfg(cci_pkg::MODE_TWO, 5'h00), r);
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0001);
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    // output returns to its snapshot value
    drv_raw(2'h2);
    wait_flag();
    drv_raw(2'h3);
    wt(12);
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0001);
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    // inversion of both outputs
    wb(1'b1, cci_pkg::ADR_CFG, cfg(cci_pkg::MODE_TWO, 5'h06), r);
    wt(12);
    chk_b(cmp_out_o, 2'h0);
    wb(1'b0, cci_pkg::ADR_CFG, 32'h0000_0000, r);
    chk_w(r, cfg(cci_pkg::MODE_TWO, 5'h06));
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0000);
    drv_raw(2'h1);
    wait_flag();
    chk_b(cmp_out_o, 2'h2);
    wb(1'b0, cci_pkg::ADR_CFG, 32'h0000_0000, r);
    chk_w(r, cfg(cci_pkg::MODE_TWO, 5'h16));
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    // simulated interrupt and the three enables
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0001, r);
    wt(2);
    chk_b({1'b0, change_flag_o}, 2'h1);
    for (int en = 0; en < 8; en++) begin
      wb(1'b1, cci_pkg::ADR_EN, 32'(en), r);
      wt(2);
      chk_b({1'b0, cmp_irq_o}, {1'b0, en == 7});
    end
    wb(1'b1, cci_pkg::ADR_EN, 32'h0000_0000, r);
    // sticky events, mask and level interrupt
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    wb(1'b0, cci_pkg::ADR_EVT, 32'h0000_0000, r);
    wb(1'b1, cci_pkg::ADR_FLAG, 32'h0000_0001, r);
    wt(2);
    chk_b({1'b0, irq_o}, 2'h0);
    wb(1'b1, cci_pkg::ADR_MSK, 32'h0000_0001, r);
    wt(2);
    chk_b({1'b0, irq_o}, 2'h1);
    wb(1'b0, cci_pkg::ADR_EVT, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0001);
    wt(2);
    chk_b({1'b0, irq_o}, 2'h0);
    drv_raw(2'h0);
    wt(12);
    wb(1'b0, cci_pkg::ADR_EVT, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0002);
    wb(1'b0, cci_pkg::ADR_MSK, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0001);
    // clock enable low freezes the reported outputs and the flag
    @(posedge clk_i);
    ce_i <= 1'b0;
    drv_raw(2'h3);
    wt(4);
    chk_b(cmp_out_o, 2'h3);
    chk_b({1'b0, change_flag_o}, 2'h1);
    @(posedge clk_i);
    ce_i <= 1'b1;
    wt(2);
    chk_b(cmp_out_o, 2'h0);
    // reset in mid run with a comparator output high
    @(posedge clk_i);
    rst_i <= 1'b1;
    cmp_raw_i <= 2'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(12);
    chk_b(cmp_out_o, 2'h1);
    chk_b({1'b0, change_flag_o}, 2'h0);
    wb(1'b0, cci_pkg::ADR_FLAG, 32'h0000_0000, r);
    chk_w(r, 32'h0000_0000);
    conclude();
  end
endmodule
